// file: pkg/fsm_pkg.sv
/*
 * constants for the fault status and masking block: i2c address, register
 * offsets, fault bit positions, reset values and stop-packet cause codes.
 * assumes a single 100 MHz core clock and a synchronous active-high reset.
 */
package fsm_pkg;
    localparam logic [6:0] I2C_ADDR = 7'h68;
    localparam logic [7:0] ADDR_FEN = 8'h01;
    localparam logic [7:0] ADDR_IEN = 8'h03;
    localparam logic [7:0] ADDR_RAW_HI = 8'hD4;
    localparam logic [7:0] ADDR_RAW_LO = 8'hD5;
    localparam logic [7:0] ADDR_MFLT_HI = 8'hD6;
    localparam logic [7:0] ADDR_MFLT_LO = 8'hD7;
    localparam logic [7:0] ADDR_MIRQ_HI = 8'hD8;
    localparam logic [7:0] ADDR_MIRQ_LO = 8'hD9;
    localparam logic [7:0] ADDR_PART_HI = 8'hFC;
    localparam logic [7:0] ADDR_PART_LO = 8'hFD;
    localparam logic [7:0] ADDR_FW = 8'hFF;
    // fault bit positions
    localparam int BIT_TEMP2 = 7;
    localparam int BIT_TEMP1 = 6;
    localparam int BIT_DIE = 5;
    localparam int BIT_EOC = 2;
    localparam int BIT_SHDN = 0;
    localparam logic [7:0] FAULT_MASK = 8'hE5;
    localparam logic [7:0] FEN_RST = 8'hE5;
    localparam logic [7:0] IEN_RST = 8'hE5;
    localparam logic [7:0] STATUS_RST = 8'h00;
    // stop packet cause codes
    localparam logic [7:0] CAUSE_EOC = 8'h01;
    localparam logic [7:0] CAUSE_DIE = 8'h02;
    localparam logic [7:0] CAUSE_TEMP = 8'h03;
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;
    localparam int SYNC_W = 7;
    // scl and sda idle high: the synchroniser resets there so no false edge follows reset
    localparam logic [SYNC_W-1:0] SYNC_RST = 7'h60;
endpackage

// file: hw/fsm_sync.sv
/*
 * two-flop synchroniser for a group of pin levels.
 * assumes the inputs are quasi-static levels relative to the core clock.
 */
module fsm_sync
    import fsm_pkg::*;
#(
    parameter int W = 1,
    parameter logic [W-1:0] RST_VAL = '0
)
(
    // clock and reset
    input wire logic core_clk_i,
    input wire logic rst_i,
    // levels
    input wire logic [W-1:0] async_i,
    output logic [W-1:0] sync_o
);
    logic [W-1:0] meta_q;

    always_ff @(posedge core_clk_i)
    begin
        if (rst_i)
        begin
            meta_q <= RST_VAL;
            sync_o <= RST_VAL;
        end
        else
        begin
            meta_q <= async_i;
            sync_o <= meta_q;
        end
    end
endmodule

// file: hw/fsm_stop_req.sv
/*
 * raises a stop-power-packet request with a cause code when an enabled
 * fault newly appears. assumes the packet sender takes it with a ready
 * strobe on the same clock.
 */
module fsm_stop_req
    import fsm_pkg::*;
(
    // clock and reset
    input wire logic core_clk_i,
    input wire logic rst_i,
    // masked fault flags
    input wire logic [7:0] mflt_i,
    // packet sender handshake
    input wire logic stop_ready_i,
    output logic stop_valid_o,
    output logic [7:0] stop_cause_o
);
    logic [7:0] prev_q;
    logic [7:0] new_w;
    logic [7:0] cause_w;

    assign new_w = mflt_i & ~prev_q;

    // remote temperature first, since it protects the battery
    always_comb
    begin
        cause_w = CAUSE_EOC;
        if (new_w[BIT_TEMP2] || new_w[BIT_TEMP1])
            cause_w = CAUSE_TEMP;
        else if (new_w[BIT_DIE] || new_w[BIT_SHDN])
            cause_w = CAUSE_DIE;
    end

    always_ff @(posedge core_clk_i)
    begin
        if (rst_i)
            prev_q <= STATUS_RST;
        else
            prev_q <= mflt_i;
    end

    // a new fault while one is pending is dropped: the link is stopping anyway
    always_ff @(posedge core_clk_i)
    begin
        if (rst_i)
        begin
            stop_valid_o <= 1'b0;
            stop_cause_o <= STATUS_RST;
        end
        else if (stop_valid_o)
        begin
            if (stop_ready_i)
                stop_valid_o <= 1'b0;
        end
        else if (|new_w)
        begin
            stop_valid_o <= 1'b1;
            stop_cause_o <= cause_w;
        end
    end
endmodule

// file: hw/fsm_top.sv
/*
 * fault status and masking with its i2c register slave.
 * assumes scl and the fault pins are asynchronous levels, sampled twice,
 * that scl runs far slower than the core clock, and that the sda and int
 * wires are pulled high outside.
 */
module fsm_top
    import fsm_pkg::*;
#(
    // arbitrary identity values
    parameter logic [7:0] PART_HI = 8'h5A,
    parameter logic [7:0] PART_LO = 8'hC3,
    parameter logic [7:0] FW_VERSION = 8'h11
)
(
    // clock and reset
    input wire logic core_clk_i,
    input wire logic rst_i,
    // i2c pins
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_o,
    // fault sources
    input wire logic remote_temp_first_i,
    input wire logic remote_temp_second_i,
    input wire logic die_over_temp_i,
    input wire logic eoc_i,
    input wire logic shutdown_req_i,
    // interrupt pin
    output logic irq_n_o,
    output logic irq_oe_o,
    // stop power packet
    input wire logic stop_ready_i,
    output logic stop_valid_o,
    output logic [7:0] stop_cause_o
);
    typedef enum {ST_IDLE, ST_ADDR, ST_AACK, ST_REG, ST_RACK, ST_WR, ST_WACK, ST_RD, ST_MACK} fsm_state_t;

    fsm_state_t st_q;
    logic [SYNC_W-1:0] pins_w;
    logic scl_s;
    logic sda_s;
    logic ts1_s;
    logic ts2_s;
    logic die_s;
    logic eoc_s;
    logic shdn_s;
    logic scl_p_q;
    logic sda_p_q;
    logic start_w;
    logic stop_w;
    logic scl_rise_w;
    logic scl_fall_w;
    logic [7:0] sh_q;
    logic [3:0] cnt_q;
    logic rw_q;
    logic ack_q;
    logic [7:0] ptr_q;
    logic wr_stb_q;
    logic [7:0] wr_addr_q;
    logic [7:0] wr_data_q;
    logic [7:0] rd_mux_w;
    logic [7:0] fen_q;
    logic [7:0] ien_q;
    logic [7:0] part_hi_q;
    logic [7:0] part_lo_q;
    logic [7:0] raw_d;
    logic [7:0] raw_q;
    logic [7:0] mflt_q;
    logic [7:0] mirq_q;

    fsm_sync #(
        .W(SYNC_W), .RST_VAL(SYNC_RST)
    ) u_sync (
        .core_clk_i(core_clk_i),
        .rst_i(rst_i),
        .async_i({scl_i, sda_i, remote_temp_first_i, remote_temp_second_i,
                  die_over_temp_i, eoc_i, shutdown_req_i}),
        .sync_o(pins_w)
    );

    assign {scl_s, sda_s, ts1_s, ts2_s, die_s, eoc_s, shdn_s} = pins_w;

    // bus edge detection on synchronised levels only
    always_ff @(posedge core_clk_i)
    begin
        if (rst_i)
        begin
            scl_p_q <= 1'b1;
            sda_p_q <= 1'b1;
        end
        else
        begin
            scl_p_q <= scl_s;
            sda_p_q <= sda_s;
        end
    end

    assign start_w = scl_s && scl_p_q && sda_p_q && !sda_s;
    assign stop_w = scl_s && scl_p_q && !sda_p_q && sda_s;
    assign scl_rise_w = scl_s && !scl_p_q;
    assign scl_fall_w = !scl_s && scl_p_q;

    // read data
    always_comb
    begin
        case (ptr_q)
            ADDR_FEN: rd_mux_w = fen_q & FAULT_MASK;
            ADDR_IEN: rd_mux_w = ien_q & FAULT_MASK;
            ADDR_RAW_LO: rd_mux_w = raw_q;
            ADDR_MFLT_LO: rd_mux_w = mflt_q;
            ADDR_MIRQ_LO: rd_mux_w = mirq_q;
            ADDR_PART_HI: rd_mux_w = part_hi_q;
            ADDR_PART_LO: rd_mux_w = part_lo_q;
            ADDR_FW: rd_mux_w = FW_VERSION;
            default: rd_mux_w = STATUS_RST;
        endcase
    end

    // i2c slave engine: data changes on scl fall, sampled on scl rise
    always_ff @(posedge core_clk_i)
    begin
        if (rst_i)
        begin
            st_q <= ST_IDLE;
            sh_q <= 8'h00;
            cnt_q <= 4'h0;
            rw_q <= 1'b0;
            ack_q <= 1'b0;
            ptr_q <= 8'h00;
            sda_oe_o <= 1'b0;
            wr_stb_q <= 1'b0;
            wr_addr_q <= 8'h00;
            wr_data_q <= 8'h00;
        end
        else
        begin
            wr_stb_q <= 1'b0;
            if (start_w)
            begin
                st_q <= ST_ADDR;
                cnt_q <= 4'h0;
                sda_oe_o <= 1'b0;
            end
            else if (stop_w)
            begin
                st_q <= ST_IDLE;
                sda_oe_o <= 1'b0;
            end
            else if (scl_rise_w)
            begin
                case (st_q)
                    ST_ADDR, ST_REG, ST_WR:
                    begin
                        sh_q <= {sh_q[6:0], sda_s};
                        cnt_q <= cnt_q + 4'h1;
                    end
                    ST_RD: cnt_q <= cnt_q + 4'h1;
                    ST_MACK: ack_q <= !sda_s;
                    default: ;
                endcase
            end
            else if (scl_fall_w)
            begin
                case (st_q)
                    ST_ADDR:
                    begin
                        if (cnt_q == BITS_PER_BYTE)
                        begin
                            if (sh_q[7:1] == I2C_ADDR)
                            begin
                                st_q <= ST_AACK;
                                rw_q <= sh_q[0];
                                sda_oe_o <= 1'b1;
                            end
                            else
                                st_q <= ST_IDLE;
                        end
                    end
                    ST_AACK:
                    begin
                        cnt_q <= 4'h0;
                        if (rw_q)
                        begin
                            st_q <= ST_RD;
                            sh_q <= rd_mux_w;
                            sda_oe_o <= !rd_mux_w[7];
                        end
                        else
                        begin
                            st_q <= ST_REG;
                            sda_oe_o <= 1'b0;
                        end
                    end
                    ST_REG:
                    begin
                        if (cnt_q == BITS_PER_BYTE)
                        begin
                            ptr_q <= sh_q;
                            st_q <= ST_RACK;
                            sda_oe_o <= 1'b1;
                        end
                    end
                    ST_RACK, ST_WACK:
                    begin
                        st_q <= ST_WR;
                        cnt_q <= 4'h0;
                        sda_oe_o <= 1'b0;
                    end
                    ST_WR:
                    begin
                        if (cnt_q == BITS_PER_BYTE)
                        begin
                            wr_stb_q <= 1'b1;
                            wr_addr_q <= ptr_q;
                            wr_data_q <= sh_q;
                            ptr_q <= ptr_q + 8'h01;
                            st_q <= ST_WACK;
                            sda_oe_o <= 1'b1;
                        end
                    end
                    ST_RD:
                    begin
                        if (cnt_q == BITS_PER_BYTE)
                        begin
                            st_q <= ST_MACK;
                            sda_oe_o <= 1'b0;
                            ptr_q <= ptr_q + 8'h01;
                        end
                        else
                        begin
                            sh_q <= {sh_q[6:0], 1'b0};
                            sda_oe_o <= !sh_q[6];
                        end
                    end
                    ST_MACK:
                    begin
                        cnt_q <= 4'h0;
                        if (ack_q)
                        begin
                            st_q <= ST_RD;
                            sh_q <= rd_mux_w;
                            sda_oe_o <= !rd_mux_w[7];
                        end
                        else
                            st_q <= ST_IDLE;
                    end
                    default: st_q <= ST_IDLE;
                endcase
            end
        end
    end

    assign sda_o = 1'b0;

    // writable registers; status and version addresses ignore writes
    always_ff @(posedge core_clk_i)
    begin
        if (rst_i)
        begin
            fen_q <= FEN_RST;
            ien_q <= IEN_RST;
            part_hi_q <= PART_HI;
            part_lo_q <= PART_LO;
        end
        else if (wr_stb_q)
        begin
            case (wr_addr_q)
                ADDR_FEN: fen_q <= wr_data_q & FAULT_MASK;
                ADDR_IEN: ien_q <= wr_data_q & FAULT_MASK;
                ADDR_PART_HI: part_hi_q <= wr_data_q;
                ADDR_PART_LO: part_lo_q <= wr_data_q;
                default: ;
            endcase
        end
    end

    // raw flags track the conditions, enables play no part
    always_comb
    begin
        raw_d = STATUS_RST;
        raw_d[BIT_TEMP2] = ts2_s;
        raw_d[BIT_TEMP1] = ts1_s;
        raw_d[BIT_DIE] = die_s;
        raw_d[BIT_EOC] = eoc_s;
        raw_d[BIT_SHDN] = shdn_s;
    end

    always_ff @(posedge core_clk_i)
    begin
        if (rst_i)
        begin
            raw_q <= STATUS_RST;
            mflt_q <= STATUS_RST;
            mirq_q <= STATUS_RST;
        end
        else
        begin
            raw_q <= raw_d;
            mflt_q <= raw_d & fen_q;
            mirq_q <= raw_d & ien_q;
        end
    end

    // pin pulled low while any enabled interrupt flag stands
    always_ff @(posedge core_clk_i)
    begin
        if (rst_i)
            irq_oe_o <= 1'b0;
        else
            irq_oe_o <= |mirq_q;
    end

    assign irq_n_o = 1'b0;

    fsm_stop_req u_stop (
        .core_clk_i(core_clk_i),
        .rst_i(rst_i),
        .mflt_i(mflt_q),
        .stop_ready_i(stop_ready_i),
        .stop_valid_o(stop_valid_o),
        .stop_cause_o(stop_cause_o)
    );

    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (rst_i);

    addr_match_a: assert property ((st_q == ST_ADDR) && scl_fall_w && (cnt_q == BITS_PER_BYTE)
        && (sh_q[7:1] != I2C_ADDR) |=> (st_q == ST_IDLE) && !sda_oe_o)
        else $error("foreign address acknowledged");
    fw_read_a: assert property ((st_q == ST_AACK) && rw_q && scl_fall_w && (ptr_q == ADDR_FW)
        |=> (sh_q == FW_VERSION) && (sda_oe_o == !FW_VERSION[7]))
        else $error("firmware version byte wrong");
    part_read_a: assert property ((st_q == ST_AACK) && rw_q && scl_fall_w && (ptr_q == ADDR_PART_HI)
        |=> (sh_q == part_hi_q))
        else $error("part code high byte wrong");
    raw_temp_a: assert property (ts2_s && ts1_s |=> raw_q[BIT_TEMP2] && raw_q[BIT_TEMP1])
        else $error("remote temperature raw bits wrong");
    raw_die_a: assert property ($past(die_s) == raw_q[BIT_DIE] && $past(eoc_s) == raw_q[BIT_EOC])
        else $error("die or charge raw bit wrong");
    raw_shdn_a: assert property (shdn_s |=> raw_q[BIT_SHDN] ##1 raw_q[BIT_SHDN] || !$past(shdn_s))
        else $error("shutdown raw bit wrong");
    resv_zero_a: assert property (((raw_q | mflt_q | mirq_q) & ~FAULT_MASK) == 8'h00)
        else $error("reserved status bit set");
    mflt_gate_a: assert property (mflt_q == (raw_q & $past(fen_q)))
        else $error("masked fault mismatch");
    mirq_gate_a: assert property (mirq_q == (raw_q & $past(ien_q)))
        else $error("masked irq mismatch");
    irq_pin_a: assert property ($rose(|mirq_q) |=> irq_oe_o && !irq_n_o)
        else $error("interrupt pin not asserted");
    irq_idle_a: assert property ((mirq_q == 8'h00) |=> !irq_oe_o)
        else $error("interrupt pin driven without cause");
    en_reset_a: assert property ($past(rst_i) |-> (fen_q == FEN_RST) && (ien_q == IEN_RST))
        else $error("enable reset value wrong");
    eoc_cause_a: assert property ($rose(mflt_q[BIT_EOC]) && ((mflt_q & ~$past(mflt_q)) == 8'h04)
        && !stop_valid_o |=> stop_valid_o && (stop_cause_o == CAUSE_EOC))
        else $error("charge end cause wrong");
    temp_cause_a: assert property ($rose(mflt_q[BIT_TEMP1]) && !stop_valid_o
        |=> stop_valid_o && (stop_cause_o == CAUSE_TEMP))
        else $error("remote temperature cause wrong");

    stop_sent_c: cover property (stop_valid_o && stop_ready_i);
    irq_seen_c: cover property ($rose(irq_oe_o));
    fen_write_c: cover property (wr_stb_q && (wr_addr_q == ADDR_FEN));
    fw_read_c: cover property ((st_q == ST_RD) && (ptr_q == ADDR_FW));
endmodule

// file: tb/fsm_host.sv
/*
 * i2c host model: master tasks for register writes and reads.
 * assumes a pull-up on sda outside; scl stands high between frames.
 */
module fsm_host
    import fsm_pkg::*;
(
    // clock
    input wire logic core_clk_i,
    // i2c wires
    output logic scl_o,
    output logic sda_oe_o,
    input wire logic sda_i
);
    timeunit 1ns;
    timeprecision 100ps;
    initial
    begin
        scl_o = 1'b1;
        sda_oe_o = 1'b0;
    end
    // host timing stays on core edges so nothing races the sampling
    task automatic tk(input int n);
        repeat (n) @(posedge core_clk_i);
        #1;
    endtask
    task automatic tx_bit(input logic b);
        sda_oe_o = ~b;
        tk(4);
        scl_o = 1'b1;
        tk(8);
        scl_o = 1'b0;
        tk(4);
    endtask
    task automatic rx_bit(output logic b);
        sda_oe_o = 1'b0;
        tk(4);
        scl_o = 1'b1;
        tk(4);
        b = sda_i;
        tk(4);
        scl_o = 1'b0;
        tk(4);
    endtask
    task automatic start();
        sda_oe_o = 1'b0;
        tk(4);
        scl_o = 1'b1;
        tk(4);
        sda_oe_o = 1'b1;
        tk(4);
        scl_o = 1'b0;
        tk(4);
    endtask
    task automatic stop();
        sda_oe_o = 1'b1;
        tk(4);
        scl_o = 1'b1;
        tk(4);
        sda_oe_o = 1'b0;
        tk(4);
    endtask
    task automatic tx_byte(input logic [7:0] d, output logic nak);
        for (int i = 7; i >= 0; i--)
            tx_bit(d[i]);
        rx_bit(nak);
    endtask
    task automatic wr(input logic [6:0] dev, input logic [7:0] ptr, input logic [7:0] d, output logic nak);
        logic n2;
        start();
        tx_byte({dev, 1'b0}, nak);
        tx_byte(ptr, n2);
        tx_byte(d, n2);
        stop();
    endtask
    task automatic rd(input logic [7:0] ptr, output logic [7:0] d);
        logic n;
        start();
        tx_byte({I2C_ADDR, 1'b0}, n);
        tx_byte(ptr, n);
        start();
        tx_byte({I2C_ADDR, 1'b1}, n);
        for (int i = 7; i >= 0; i--)
            rx_bit(d[i]);
        tx_bit(1'b1);
        stop();
    endtask
    // two-byte read: master ack after the first byte, pointer steps on its own
    task automatic rd2(input logic [7:0] ptr, output logic [7:0] d0, output logic [7:0] d1);
        logic n;
        start();
        tx_byte({I2C_ADDR, 1'b0}, n);
        tx_byte(ptr, n);
        start();
        tx_byte({I2C_ADDR, 1'b1}, n);
        for (int i = 7; i >= 0; i--)
            rx_bit(d0[i]);
        tx_bit(1'b0);
        for (int i = 7; i >= 0; i--)
            rx_bit(d1[i]);
        tx_bit(1'b1);
        stop();
    endtask
endmodule

// file: tb/testbench.sv
/*
 * self-checking bench: reset values, a table of fault cases, then
 * refusals and a mid-run reset. assumes fsm_host and pull-ups on sda, int.
 */
module testbench
    import fsm_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    // arbitrary identity values
    localparam logic [7:0] P_HI = 8'h4B;
    localparam logic [7:0] P_LO = 8'h2D;
    localparam logic [7:0] P_FW = 8'h36;
    typedef struct packed {logic [7:0] fen; logic [7:0] ien; logic [4:0] p; logic [7:0] c;} fsm_row_t;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [4:0] pins = 5'h00;
    logic rdy = 1'b0;
    logic scl, h_oe, sda_o, sda_oe, sda, irq_n, irq_oe, irq_w, sv, n;
    logic [7:0] cause, raw, mf, mi;
    int n_errors = 0;
    int compares = 0;
    fsm_row_t r;
    logic [15:0] rv [12] = '{{ADDR_FEN, FEN_RST}, {ADDR_IEN, IEN_RST}, {ADDR_RAW_HI, STATUS_RST},
        {ADDR_RAW_LO, STATUS_RST}, {ADDR_MFLT_HI, STATUS_RST}, {ADDR_MFLT_LO, STATUS_RST},
        {ADDR_MIRQ_HI, STATUS_RST}, {ADDR_MIRQ_LO, STATUS_RST}, {ADDR_PART_HI, P_HI},
        {ADDR_PART_LO, P_LO}, {ADDR_FW, P_FW}, {8'h02, 8'h00}};
    fsm_row_t rows [10] = '{{8'hE5, 8'hE5, 5'h02, CAUSE_EOC}, {8'hE5, 8'hE5, 5'h01, CAUSE_DIE},
        {8'hE5, 8'hE5, 5'h04, CAUSE_DIE}, {8'hE5, 8'hE5, 5'h08, CAUSE_TEMP},
        {8'hE5, 8'hE5, 5'h10, CAUSE_TEMP}, {8'h00, 8'hE5, 5'h02, 8'h00},
        {8'hE5, 8'h00, 5'h04, CAUSE_DIE}, {8'h00, 8'h00, 5'h1F, 8'h00},
        {8'h04, 8'hFF, 5'h16, CAUSE_EOC}, {8'hFF, 8'hE5, 5'h1F, CAUSE_TEMP}};
    // open-drain wires with pull-ups
    assign sda = ~(h_oe | (sda_oe & ~sda_o));
    assign irq_w = ~(irq_oe & ~irq_n);
    always #5 clk = ~clk;
    fsm_host i_host (.core_clk_i(clk), .scl_o(scl), .sda_oe_o(h_oe), .sda_i(sda));
    fsm_top #(.PART_HI(P_HI), .PART_LO(P_LO), .FW_VERSION(P_FW)) i_dut (
        .core_clk_i(clk), .rst_i(rst), .scl_i(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe_o(sda_oe),
        .remote_temp_first_i(pins[3]), .remote_temp_second_i(pins[4]), .die_over_temp_i(pins[2]),
        .eoc_i(pins[1]), .shutdown_req_i(pins[0]), .irq_n_o(irq_n), .irq_oe_o(irq_oe),
        .stop_ready_i(rdy), .stop_valid_o(sv), .stop_cause_o(cause));
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic final_report();
        $display("errors=%0d compares=%0d", n_errors, compares);
        if (n_errors == 0 && compares > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic tk(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask
    task automatic rchk(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] d;
        i_host.rd(a, d);
        chk(d, e);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic k;
        i_host.wr(I2C_ADDR, a, d, k);
        chk(k, 1'b0);
    endtask
    // handshake pulse; the request drops on the same edge that sees ready
    task automatic take();
        rdy = 1'b1;
        tk(1);
        rdy = 1'b0;
        tk(2);
    endtask
    initial
    begin
        #900us;
        n_errors++;
        final_report();
    end
    initial
    begin
        tk(16);
        rst = 1'b0;
        tk(6);
        chk(irq_w, 1'b1);
        chk(sv, 1'b0);
        foreach (rv[k])
            rchk(rv[k][15:8], rv[k][7:0]);
        foreach (rows[k])
        begin
            r = rows[k];
            wr(ADDR_FEN, r.fen);
            wr(ADDR_IEN, r.ien);
            rchk(ADDR_FEN, r.fen & FAULT_MASK);
            rchk(ADDR_IEN, r.ien & FAULT_MASK);
            raw = {r.p[4], r.p[3], r.p[2], 2'b00, r.p[1], 1'b0, r.p[0]};
            mf = raw & r.fen;
            mi = raw & r.ien & FAULT_MASK;
            pins = r.p;
            tk(6);
            chk(sv, mf != 8'h00);
            if (mf != 8'h00)
                chk(cause, r.c);
            chk(irq_w, mi == 8'h00);
            rchk(ADDR_RAW_LO, raw);
            rchk(ADDR_MFLT_LO, mf);
            rchk(ADDR_MIRQ_LO, mi);
            rchk(ADDR_MIRQ_HI, 8'h00);
            take();
            chk(sv, 1'b0);
            pins = 5'h00;
            tk(6);
        end
        // a fault that rises while a packet waits gets no packet of its own
        pins = 5'h02;
        tk(6);
        chk(cause, CAUSE_EOC);
        pins = 5'h06;
        tk(6);
        chk(cause, CAUSE_EOC);
        take();
        tk(6);
        chk(sv, 1'b0);
        pins = 5'h00;
        tk(6);
        wr(ADDR_RAW_LO, 8'hFF);
        rchk(ADDR_RAW_LO, 8'h00);
        wr(ADDR_FW, 8'h00);
        rchk(ADDR_FW, P_FW);
        wr(ADDR_PART_HI, 8'h3C);
        rchk(ADDR_PART_HI, 8'h3C);
        i_host.wr(7'h69, ADDR_FEN, 8'h00, n);
        chk(n, 1'b1);
        rchk(ADDR_FEN, FEN_RST);
        wr(ADDR_FEN, 8'h00);
        pins = 5'h02;
        tk(6);
        chk(irq_w, 1'b0);
        rst = 1'b1;
        tk(3);
        chk(irq_w, 1'b1);
        chk(sv, 1'b0);
        pins = 5'h00;
        tk(3);
        rst = 1'b0;
        tk(6);
        rchk(ADDR_FEN, FEN_RST);
        i_host.rd2(ADDR_PART_HI, raw, mf);
        chk(raw, P_HI);
        chk(mf, P_LO);
        final_report();
    end
endmodule
